// ### pkg/sleep_wake_defines.vh
`ifndef SLEEP_WAKE_DEFINES_VH
`define SLEEP_WAKE_DEFINES_VH
`define ADDR_VOLTAGE_DETECT_CONTROL 9'h1E3
`define ADDR_VOLTAGE_COMPARATOR_STATUS 9'h1E4
`define ADDR_MONITOR_DUTY_TRIM 9'h1EB
`define ADDR_SYSTEM_STATUS_CONTROL 9'h0FF
`define SLEEP_BIT 3
`define THRESH_LSB 4
`define THRESH_MSB 5
`define TRIP_LSB 0
`define TRIP_MSB 2
`define DUTY_LSB 6
`define DUTY_MSB 7
`define RESET_VALUE_8 8'h00
`define THRESH_2V7 2'h0
`define THRESH_3V 2'h1
`define THRESH_5V 2'h2
`define THRESH_NO_RESET 2'h3
`define DUTY_128 2'h0
`define DUTY_512 2'h1
`define DUTY_32 2'h2
`define DUTY_8 2'h3
`define DUTY_PERIOD_128 10'h07F
`define DUTY_PERIOD_512 10'h1FF
`define DUTY_PERIOD_32 10'h01F
`define DUTY_PERIOD_8 10'h007
`endif

// ### src/sleep_wake_voltage_monitor.v
// Overview of operation
// - Sleep write raises bus hold request immediately
// - Core grants hold one edge after request
// - Power-down strobe on falling edge after grant
// - Strobe gates flash, oscillator, filter, bandgap
// - Any unmasked interrupt wakes, ignoring global enable
// - Servicing waking interrupt left to enables
// - Wake interrupt synchronised on slow falling edge
// - Next slow rising edge releases power-down
// - Following slow rising edge samples comparators
// - Next slow falling edge drops hold request
// - Interrupt to running in 2-3 slow periods, 61-92 us
// - Next instruction runs before interrupt service
// - Threshold field selects reset trip range
// - Code 11 disables reset, status still readable
// - Status bit one shows low-voltage trip
// - Status bit zero shows precise reset trip
// - Comparator status read-only, upper bits zero
// - Duty field sets monitor on-time ratio while powered down
// - Monitor registers respond only in extended bank, sleep write only outside it
`timescale 1ns/1ps
`default_nettype none
`include "sleep_wake_defines.vh"
module sleep_wake_voltage_monitor (
  input wire core_clk,
  input wire rst_n,
  input wire slow_clk,
  input wire [8:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_write,
  input wire io_read,
  input wire extended_bank_flag,
  output reg [7:0] io_rdata,
  output wire bus_hold_request,
  input wire bus_hold_grant,
  output wire power_down_strobe,
  output wire flash_power_off,
  output wire fast_osc_power_off,
  output wire fast_transient_filter_power_off,
  output wire bandgap_power_off,
  input wire unmasked_irq_pending,
  input wire low_voltage_raw,
  input wire precise_reset_raw,
  output reg low_voltage_detect,
  output reg precise_reset_flag,
  output reg precise_reset_request,
  output reg [1:0] reset_threshold_select,
  output reg [2:0] trip_point_select,
  output reg [1:0] monitor_duty_cycle,
  output reg monitor_enable
);
  localparam ST_RUN = 3'h0;
  localparam ST_HOLD = 3'h1;
  localparam ST_GRANTED = 3'h2;
  localparam ST_ASLEEP = 3'h3;
  localparam ST_PWRUP = 3'h4;
  localparam ST_SAMPLE = 3'h5;
  localparam ST_RELEASE = 3'h6;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg pd_reg;
  reg pd_fall_reg;
  reg [1:0] slow_sync_reg;
  reg slow_prev_reg;
  reg [1:0] irq_sync_reg;
  reg [1:0] lv_sync_reg;
  reg [1:0] pr_sync_reg;
  reg [9:0] duty_cnt_reg;
  reg [9:0] duty_period;
  reg [7:0] rdata_next;

  wire slow_rise = slow_sync_reg[1] & ~slow_prev_reg;
  wire slow_fall = ~slow_sync_reg[1] & slow_prev_reg;
  wire bank_hit = extended_bank_flag;
  wire wr_ctrl = io_write & bank_hit & (io_addr == `ADDR_VOLTAGE_DETECT_CONTROL);
  wire wr_duty = io_write & bank_hit & (io_addr == `ADDR_MONITOR_DUTY_TRIM);
  wire sleep_write = io_write & ~extended_bank_flag &
    (io_addr == `ADDR_SYSTEM_STATUS_CONTROL) & io_wdata[`SLEEP_BIT];

  // request held from sleep write until release
  assign bus_hold_request = (state_reg != ST_RUN) | sleep_write;
  assign power_down_strobe = pd_reg | pd_fall_reg;
  assign flash_power_off = power_down_strobe;
  assign fast_osc_power_off = power_down_strobe;
  assign fast_transient_filter_power_off = power_down_strobe;
  assign bandgap_power_off = power_down_strobe;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_sync_reg <= 2'h0;
      slow_prev_reg <= 1'b0;
      irq_sync_reg <= 2'h0;
      lv_sync_reg <= 2'h0;
      pr_sync_reg <= 2'h0;
    end else begin
      slow_sync_reg <= {slow_sync_reg[0], slow_clk};
      slow_prev_reg <= slow_sync_reg[1];
      irq_sync_reg <= {irq_sync_reg[0], unmasked_irq_pending};
      lv_sync_reg <= {lv_sync_reg[0], low_voltage_raw};
      pr_sync_reg <= {pr_sync_reg[0], precise_reset_raw};
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (sleep_write) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (bus_hold_grant) begin
          state_next = ST_GRANTED;
        end
      end
      ST_GRANTED: begin
        if (pd_fall_reg) begin
          state_next = ST_ASLEEP;
        end
      end
      ST_ASLEEP: begin
        // any unmasked interrupt, global enable ignored
        if (irq_sync_reg[1] & slow_fall) begin
          state_next = ST_PWRUP;
        end
      end
      ST_PWRUP: begin
        if (slow_rise) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (slow_rise) begin
          state_next = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // wake span set by slow edges
        if (slow_fall) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // no interrupt is forced on wake
  // core resumes at next instruction
  // The waking interrupt only ends the hold; servicing stays with the core's enables

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
      pd_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // strobe held from fall capture until wake rise
      if (state_reg == ST_PWRUP && slow_rise) begin
        pd_reg <= 1'b0;
      end else if (state_reg == ST_GRANTED && pd_fall_reg) begin
        pd_reg <= 1'b1;
      end
    end
  end

  // assert strobe on falling core edge after grant
  always @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_fall_reg <= 1'b0;
    end else begin
      pd_fall_reg <= (state_reg == ST_GRANTED) & bus_hold_grant;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_threshold_select <= 2'h0;
      trip_point_select <= 3'h0;
      monitor_duty_cycle <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        reset_threshold_select <= io_wdata[`THRESH_MSB:`THRESH_LSB];
        trip_point_select <= io_wdata[`TRIP_MSB:`TRIP_LSB];
      end
      if (wr_duty) begin
        monitor_duty_cycle <= io_wdata[`DUTY_MSB:`DUTY_LSB];
      end
    end
  end

  // Comparator outputs are unsettled while powered down, so hold the last sample
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_voltage_detect <= 1'b0;
      precise_reset_flag <= 1'b0;
      precise_reset_request <= 1'b0;
    end else begin
      if (!power_down_strobe && state_reg != ST_SAMPLE) begin
        low_voltage_detect <= lv_sync_reg[1];
        precise_reset_flag <= pr_sync_reg[1];
      end else if (state_reg == ST_SAMPLE && slow_rise) begin
        low_voltage_detect <= lv_sync_reg[1];
        precise_reset_flag <= pr_sync_reg[1];
      end
      precise_reset_request <= precise_reset_flag &
        (reset_threshold_select != `THRESH_NO_RESET);
    end
  end

  always @* begin
    case (monitor_duty_cycle)
      `DUTY_128: duty_period = `DUTY_PERIOD_128;
      `DUTY_512: duty_period = `DUTY_PERIOD_512;
      `DUTY_32: duty_period = `DUTY_PERIOD_32;
      default: duty_period = `DUTY_PERIOD_8;
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_cnt_reg <= 10'h000;
      monitor_enable <= 1'b1;
    end else begin
      if (!power_down_strobe) begin
        duty_cnt_reg <= 10'h000;
        monitor_enable <= 1'b1;
      end else if (slow_rise) begin
        // one slow period on per ratio
        if (duty_cnt_reg >= duty_period) begin
          duty_cnt_reg <= 10'h000;
        end else begin
          duty_cnt_reg <= duty_cnt_reg + 10'h001;
        end
        monitor_enable <= (duty_cnt_reg >= duty_period);
      end
    end
  end

  always @* begin
    rdata_next = `RESET_VALUE_8;
    if (io_read && bank_hit) begin
      case (io_addr)
        `ADDR_VOLTAGE_DETECT_CONTROL: begin
          rdata_next = {2'h0, reset_threshold_select, 1'b0, trip_point_select};
        end
        `ADDR_VOLTAGE_COMPARATOR_STATUS: begin
          rdata_next = {6'h00, low_voltage_detect, precise_reset_flag};
        end
        `ADDR_MONITOR_DUTY_TRIM: begin
          rdata_next = {monitor_duty_cycle, 6'h00};
        end
        default: begin
          rdata_next = `RESET_VALUE_8;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= `RESET_VALUE_8;
    end else begin
      io_rdata <= rdata_next;
    end
  end
endmodule
`default_nettype wire

// ### tb/core_hold_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_hold_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic bus_hold_request,
  output logic bus_hold_grant
);
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      bus_hold_grant <= 1'b0;
    else
      bus_hold_grant <= bus_hold_request;
  end
endmodule
`default_nettype wire

// ### tb/sleep_wake_voltage_monitor_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_props (
  input wire core_clk,
  input wire rst_n,
  input wire [8:0] io_addr,
  input wire [7:0] io_wdata,
  input wire io_write,
  input wire io_read,
  input wire extended_bank_flag,
  input wire [7:0] io_rdata,
  input wire bus_hold_request,
  input wire bus_hold_grant,
  input wire power_down_strobe,
  input wire flash_power_off,
  input wire bandgap_power_off,
  input wire unmasked_irq_pending,
  input wire precise_reset_request,
  input wire [1:0] reset_threshold_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic woke_reg;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      woke_reg <= 1'b0;
    else
      woke_reg <= bus_hold_request && (woke_reg || unmasked_irq_pending);
  end
  sequence s_sleep_wr;
    io_write && io_addr == 9'h0FF && !extended_bank_flag && io_wdata[3] && !bus_hold_grant;
  endsequence
  sequence s_granted;
    $rose(bus_hold_grant) && bus_hold_request;
  endsequence
  a_sleep_raises_hold: assert property (s_sleep_wr |-> bus_hold_request)
    else $error("no hold request");
  a_grant_to_strobe: assert property (s_granted |-> ##[1:3] power_down_strobe)
    else $error("strobe late");
  a_strobe_needs_grant: assert property ($rose(power_down_strobe) |-> bus_hold_grant)
    else $error("strobe before grant");
  a_gates_follow_strobe: assert property (flash_power_off == power_down_strobe && bandgap_power_off == power_down_strobe)
    else $error("gate mismatch");
  a_only_irq_wakes: assert property ($fell(power_down_strobe) |-> woke_reg)
    else $error("wake without irq");
  a_strobe_under_hold: assert property (power_down_strobe |-> bus_hold_request)
    else $error("strobe without hold");
  a_status_upper_zero: assert property (io_read && io_addr == 9'h1E4 |=> io_rdata[7:2] == 6'h00)
    else $error("status upper bits");
  a_wrong_bank_zero: assert property (io_read && !extended_bank_flag |=> io_rdata == 8'h00)
    else $error("bank zero read");
  a_no_reset_code3: assert property (precise_reset_request |-> reset_threshold_select != 2'h3)
    else $error("reset at code 3");
endmodule
bind sleep_wake_voltage_monitor sleep_wake_props u_props (.*);
`default_nettype wire

// ### tb/sleep_wake_voltage_monitor_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_voltage_monitor_bench;
  logic core_clk = 1'b0;
  logic slow_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic xb = 1'b1;
  logic irq = 1'b0;
  logic lv = 1'b0;
  logic pr = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] x = 32'h60;
  logic [7:0] exp_q[$];
  wire [7:0] rdata;
  wire req, grant, pd, en, prq;
  wire [1:0] thr, duty;
  wire [2:0] trip;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  realtime t0;
  always #5 core_clk = ~core_clk;
  // Real 32 kHz rate so the wake time is meaningful
  always #15259 slow_clk = ~slow_clk;
  sleep_wake_voltage_monitor u_dut (.core_clk(core_clk), .rst_n(rst_n), .slow_clk(slow_clk),
    .io_addr(addr), .io_wdata(wdata), .io_write(wr), .io_read(rd), .extended_bank_flag(xb),
    .io_rdata(rdata), .bus_hold_request(req), .bus_hold_grant(grant), .power_down_strobe(pd),
    .flash_power_off(), .fast_osc_power_off(), .fast_transient_filter_power_off(),
    .bandgap_power_off(), .unmasked_irq_pending(irq), .low_voltage_raw(lv),
    .precise_reset_raw(pr), .low_voltage_detect(), .precise_reset_flag(),
    .precise_reset_request(prq), .reset_threshold_select(thr), .trip_point_select(trip),
    .monitor_duty_cycle(duty), .monitor_enable(en));
  core_hold_model u_core (.core_clk(core_clk), .rst_n(rst_n), .bus_hold_request(req),
    .bus_hold_grant(grant));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    checked++;
    if (got !== want) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic acc(input logic w, input logic b, input logic [8:0] a, input logic [7:0] d);
    xb = b;
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(posedge core_clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic rdx(input logic b, input logic [8:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, b, a, 8'h00);
  endtask
  task automatic wt(input logic sel, input logic v, input int lim);
    n = 0;
    while ((sel ? req : pd) !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    #1;
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk) begin
    rd_d <= rd;
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      print_verdict();
    end
  end
  // Read data is registered, so compare mid-cycle once it has settled
  always @(negedge core_clk) begin
    if (rd_d)
      chk(rdata, exp_q.pop_front());
  end
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    rdx(1'b1, 9'h1E3, 8'h00);
    rdx(1'b1, 9'h1E4, 8'h00);
    rdx(1'b1, 9'h1EB, 8'h00);
    for (int i = 0; i < 4; i++) begin
      x = nxt(x);
      acc(1'b1, 1'b1, 9'h1E3, {x[7:6], i[1:0], x[3], 1'b1, x[1:0]});
      acc(1'b1, 1'b1, 9'h1EB, {i[1:0], x[5:0]});
      rdx(1'b1, 9'h1E3, {2'h0, i[1:0], 2'h1, x[1:0]});
      rdx(1'b1, 9'h1EB, {i[1:0], 6'h00});
      chk({thr, duty, 1'b0, trip}, {i[1:0], i[1:0], 2'h1, x[1:0]});
    end
    acc(1'b1, 1'b0, 9'h1E3, 8'h00);
    chk({6'h00, thr}, 8'h03);
    rdx(1'b0, 9'h1E3, 8'h00);
    acc(1'b1, 1'b1, 9'h1E4, 8'hFF);
    lv = 1'b1;
    pr = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    rdx(1'b1, 9'h1E4, 8'h03);
    chk({7'h00, prq}, 8'h00);
    acc(1'b1, 1'b1, 9'h1E3, 8'h24);
    repeat (4) @(posedge core_clk);
    #1;
    chk({7'h00, prq}, 8'h01);
    lv = 1'b0;
    pr = 1'b0;
    // pins, timer clocks set by firmware
    // core clock, oscillator mode outside block
    acc(1'b1, 1'b0, 9'h0FF, 8'h08);
    wt(1'b0, 1'b1, 20);
    chk({7'h00, pd}, 8'h01);
    repeat (2) @(negedge slow_clk);
    n = 0;
    repeat (16) begin
      @(negedge slow_clk);
      n += en;
    end
    chk(n[7:0], 8'h02);
    t0 = $realtime;
    irq = 1'b1;
    wt(1'b1, 1'b0, 12000);
    chk({6'h00, req, pd}, 8'h00);
    chk({7'h00, ($realtime - t0) <= 105000.0}, 8'h01);
    irq = 1'b0;
    print_verdict();
  end
endmodule
`default_nettype wire
